//--- pkg/grr_pkg.sv
package grr_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ          = 200;
   localparam int BAUD_KBAUD       = 1000;
   localparam int BIT_CYCLES       = (CLK_MHZ * 1000) / BAUD_KBAUD;
   localparam int FRAME_BYTES      = 6;
   localparam int CHAR_BITS        = 10;
   localparam int PROC_TIME_US     = 100;
   localparam int PROC_CYCLES      = PROC_TIME_US * CLK_MHZ;
   localparam int SLOW_RATE_HZ     = 1600;
   localparam int FAST_RATE_HZ     = 5000;
   localparam int SLOW_PERIOD_CYC  = (CLK_MHZ * 1000000) / SLOW_RATE_HZ;
   localparam int FAST_PERIOD_CYC  = (CLK_MHZ * 1000000) / FAST_RATE_HZ;
   localparam int POWERUP_TIME_MS  = 1000;
   localparam int POWERUP_CYCLES   = POWERUP_TIME_MS * CLK_MHZ * 1000;
   localparam int CNT_W            = 28;
   // ----------------------------------------------------------------
   // frame layout and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_NORMAL = 8'hC0;
   localparam logic [7:0] STATUS_BIT_FAIL = 8'h3C;
   localparam logic [2:0] BYTE_IDX_RESET = 3'h0;
   localparam logic [3:0] BIT_IDX_RESET  = 4'h0;
endpackage

//--- pkg/grr_if.sv
`timescale 1ns/1ps
interface grr_if;
   logic strobe;
   logic tx_en;
   logic tx_data;
   logic health_ok;
   modport dev  (input strobe, input tx_en, output tx_data, output health_ok);
   modport host (output strobe, output tx_en, input tx_data, input health_ok);
endinterface

//--- core/grr_device.sv
`timescale 1ns/1ps
module grr_device
   import grr_pkg::*;
#(
   parameter int PROC_CYC = grr_pkg::PROC_CYCLES
)
(
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   grr_if.dev               link,
   input  wire logic [15:0] angle_in,
   input  wire logic        bit_fail_in,
   output logic             busy_out
);
   import grr_pkg::*;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_SEND = 2'b11,
                             ST_PROC = 2'b10} grr_state_e;

   // ----------------------------------------------------------------
   // pin synchronisers: three stages, change once stages two and three agree
   // ----------------------------------------------------------------
   logic [2:0] stb_sync_reg, stb_sync_next;
   logic [2:0] en_sync_reg, en_sync_next;
   logic       stb_lvl_reg, stb_lvl_next;
   logic       en_lvl_reg, en_lvl_next;

   // shift chains and filtered levels
   always_comb
   begin
      stb_sync_next = {stb_sync_reg[1:0], link.strobe};
      en_sync_next  = {en_sync_reg[1:0], link.tx_en};
      stb_lvl_next  = (stb_sync_reg[2] == stb_sync_reg[1]) ? stb_sync_reg[1] : stb_lvl_reg;
      en_lvl_next   = (en_sync_reg[2] == en_sync_reg[1]) ? en_sync_reg[1] : en_lvl_reg;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         stb_sync_reg <= 3'h0;
         en_sync_reg  <= 3'h0;
         stb_lvl_reg  <= 1'b0;
         en_lvl_reg   <= 1'b0;
      end
      else
      begin
         stb_sync_reg <= stb_sync_next;
         en_sync_reg  <= en_sync_next;
         stb_lvl_reg  <= stb_lvl_next;
         en_lvl_reg   <= en_lvl_next;
      end
   end

   logic stb_rise;
   assign stb_rise = stb_lvl_next & ~stb_lvl_reg;

   // ----------------------------------------------------------------
   // frame engine
   // ----------------------------------------------------------------
   grr_state_e        state_reg, state_next;
   logic [47:0]       frame_reg, frame_next;
   logic [2:0]        byte_reg, byte_next;
   logic [3:0]        bit_reg, bit_next;
   logic [CNT_W-1:0]  cnt_reg, cnt_next;
   logic [CNT_W-1:0]  proc_reg, proc_next;
   logic              pend_reg, pend_next;
   logic              txd_reg, txd_next;
   logic              ok_reg, ok_next;
   logic [9:0]        chr;

   // character: stop bit, data lsb first, start bit at index 0
   assign chr = {1'b1, frame_reg[47:40], 1'b0};

   always_comb
   begin
      state_next = state_reg;
      frame_next = frame_reg;
      byte_next  = byte_reg;
      bit_next   = bit_reg;
      cnt_next   = cnt_reg;
      pend_next  = pend_reg;
      txd_next   = 1'b1;
      ok_next    = ~bit_fail_in;
      // processing timer runs from each capture; a later capture waits for it
      proc_next  = (proc_reg != '0) ? proc_reg - CNT_W'(1) : proc_reg;
      if (stb_rise)
      begin
         pend_next = 1'b1;
      end
      case (state_reg)
         ST_IDLE:
         begin
            if (pend_reg && proc_reg == '0)
            begin
               pend_next  = stb_rise;
               // status byte first, then angle, then three filler bytes
               frame_next = {bit_fail_in ? STATUS_BIT_FAIL : STATUS_NORMAL,
                             angle_in, 16'h0000, 8'h00};
               proc_next  = CNT_W'(PROC_CYC);
               state_next = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            // enable gates the frame; held high acts immediately
            if (en_lvl_reg)
            begin
               byte_next  = BYTE_IDX_RESET;
               bit_next   = BIT_IDX_RESET;
               cnt_next   = '0;
               state_next = ST_SEND;
            end
         end
         ST_SEND:
         begin
            txd_next = chr[bit_reg];
            if (!en_lvl_reg)
            begin
               txd_next   = 1'b1;
               state_next = ST_PROC;
            end
            else if (cnt_reg == CNT_W'(BIT_CYCLES - 1))
            begin
               cnt_next = '0;
               if (bit_reg == 4'(CHAR_BITS - 1))
               begin
                  bit_next   = BIT_IDX_RESET;
                  frame_next = {frame_reg[39:0], 8'h00};
                  if (byte_reg == 3'(FRAME_BYTES - 1))
                  begin
                     state_next = ST_PROC;
                  end
                  else
                  begin
                     byte_next = byte_reg + 3'h1;
                  end
               end
               else
               begin
                  bit_next = bit_reg + 4'h1;
               end
            end
            else
            begin
               cnt_next = cnt_reg + CNT_W'(1);
            end
         end
         ST_PROC:
         begin
            // new enable ignored until processing done
            if (proc_reg == '0)
            begin
               state_next = ST_IDLE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         state_reg <= ST_IDLE;
         frame_reg <= 48'h0;
         byte_reg  <= BYTE_IDX_RESET;
         bit_reg   <= BIT_IDX_RESET;
         cnt_reg   <= '0;
         proc_reg  <= '0;
         pend_reg  <= 1'b0;
         txd_reg   <= 1'b1;
         ok_reg    <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         frame_reg <= frame_next;
         byte_reg  <= byte_next;
         bit_reg   <= bit_next;
         cnt_reg   <= cnt_next;
         proc_reg  <= proc_next;
         pend_reg  <= pend_next;
         txd_reg   <= txd_next;
         ok_reg    <= ok_next;
      end
   end

   assign link.tx_data   = txd_reg;
   assign link.health_ok = ok_reg;
   assign busy_out       = (state_reg != ST_IDLE);
endmodule

//--- core/grr_host.sv
`timescale 1ns/1ps
module grr_host
   import grr_pkg::*;
#(
   parameter int POWERUP_CYC = grr_pkg::POWERUP_CYCLES
)
(
   input  wire logic        sys_clk_in,
   input  wire logic        reset_in,
   grr_if.host              link,
   input  wire logic        sample_req_in,
   input  wire logic        fast_variant_in,
   input  wire logic        gated_mode_in,
   input  wire logic        enable_req_in,
   output logic             sample_taken_out,
   output logic [7:0]       rx_byte_out,
   output logic             rx_valid_out,
   output logic             health_ok_out
);
   import grr_pkg::*;

   // ----------------------------------------------------------------
   // strobe generator with rate limit
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] gap_reg, gap_next;
   logic [7:0]       stbw_reg, stbw_next;
   logic             stb_reg, stb_next;
   logic             en_reg, en_next;
   logic             take;

   // a request waits until the variant's minimum period has passed
   assign take = sample_req_in && gap_reg == '0;

   always_comb
   begin
      gap_next  = (gap_reg != '0) ? gap_reg - CNT_W'(1) : gap_reg;
      stbw_next = (stbw_reg != 8'h00) ? stbw_reg - 8'h01 : stbw_reg;
      stb_next  = stbw_reg != 8'h00;
      if (take)
      begin
         gap_next  = CNT_W'(fast_variant_in ? FAST_PERIOD_CYC : SLOW_PERIOD_CYC);
         stbw_next = 8'(BIT_CYCLES);
         stb_next  = 1'b1;
      end
      en_next = gated_mode_in ? enable_req_in : 1'b1;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         gap_reg  <= '0;
         stbw_reg <= 8'h00;
         stb_reg  <= 1'b0;
         en_reg   <= 1'b0;
      end
      else
      begin
         gap_reg  <= gap_next;
         stbw_reg <= stbw_next;
         stb_reg  <= stb_next;
         en_reg   <= en_next;
      end
   end

   assign link.strobe      = stb_reg;
   assign link.tx_en       = en_reg;
   assign sample_taken_out = take;

   // ----------------------------------------------------------------
   // receiver and health qualification
   // ----------------------------------------------------------------
   logic [2:0]       rxs_reg, rxs_next;
   logic [2:0]       oks_reg, oks_next;
   logic             rxl_reg, rxl_next;
   logic             busy_reg, busy_next;
   logic [7:0]       cnt_reg, cnt_next;
   logic [3:0]       bit_reg, bit_next;
   logic [7:0]       sh_reg, sh_next;
   logic [7:0]       byte_reg, byte_next;
   logic             val_reg, val_next;
   logic [CNT_W-1:0] pu_reg, pu_next;
   logic             hok_reg, hok_next;

   always_comb
   begin
      rxs_next  = {rxs_reg[1:0], link.tx_data};
      oks_next  = {oks_reg[1:0], link.health_ok};
      rxl_next  = (rxs_reg[2] == rxs_reg[1]) ? rxs_reg[1] : rxl_reg;
      busy_next = busy_reg;
      cnt_next  = cnt_reg;
      bit_next  = bit_reg;
      sh_next   = sh_reg;
      byte_next = byte_reg;
      val_next  = 1'b0;
      pu_next   = (pu_reg != '0) ? pu_reg - CNT_W'(1) : pu_reg;
      // health follows only agreeing stages, masked until power-up time ran out
      hok_next  = (oks_reg[2] == oks_reg[1]) ? oks_reg[1] : hok_reg;
      if (pu_reg != '0)
      begin
         hok_next = 1'b0;
      end
      if (!busy_reg)
      begin
         if (rxl_reg && !rxl_next)
         begin
            busy_next = 1'b1;
            cnt_next  = 8'(BIT_CYCLES / 2);
            bit_next  = 4'h0;
         end
      end
      else if (cnt_reg == 8'(BIT_CYCLES - 1))
      begin
         cnt_next = 8'h00;
         bit_next = bit_reg + 4'h1;
         if (bit_reg >= 4'h1 && bit_reg <= 4'h8)
         begin
            sh_next = {rxl_reg, sh_reg[7:1]};
         end
         if (bit_reg == 4'(CHAR_BITS - 1))
         begin
            busy_next = 1'b0;
            byte_next = sh_reg;
            val_next  = rxl_reg;
         end
      end
      else
      begin
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         rxs_reg  <= 3'h7;
         oks_reg  <= 3'h0;
         rxl_reg  <= 1'b1;
         busy_reg <= 1'b0;
         cnt_reg  <= 8'h00;
         bit_reg  <= 4'h0;
         sh_reg   <= 8'h00;
         byte_reg <= 8'h00;
         val_reg  <= 1'b0;
         pu_reg   <= CNT_W'(POWERUP_CYC);
         hok_reg  <= 1'b0;
      end
      else
      begin
         rxs_reg  <= rxs_next;
         oks_reg  <= oks_next;
         rxl_reg  <= rxl_next;
         busy_reg <= busy_next;
         cnt_reg  <= cnt_next;
         bit_reg  <= bit_next;
         sh_reg   <= sh_next;
         byte_reg <= byte_next;
         val_reg  <= val_next;
         pu_reg   <= pu_next;
         hok_reg  <= hok_next;
      end
   end

   assign rx_byte_out   = byte_reg;
   assign rx_valid_out  = val_reg;
   assign health_ok_out = hok_reg;
endmodule

//--- tb/grr_link_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// link checker
// ------------------------------------------------------------
module grr_link_props
   import grr_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic strobe,
   input wire logic tx_en,
   input wire logic tx_data,
   input wire logic health_ok
);
   logic        prev_reg;
   logic [16:0] run_reg;
   logic [16:0] gap_reg;
   logic [16:0] fr_reg;
   logic [8:0]  stb_reg;
   logic        pend_reg;
   logic        start_w;
   logic        inner_w;
   logic        rise_w;
   // a fall after more than nine high bits can only open a frame
   assign start_w = !tx_data && prev_reg && (run_reg > 17'(9 * BIT_CYCLES));
   assign inner_w = !tx_data && prev_reg && !start_w;
   assign rise_w  = strobe && (stb_reg == 9'h0);
   // counters saturate so long idle spans never wrap
   always_ff @(posedge sys_clk_in)
   begin
      if (reset_in)
      begin
         prev_reg <= 1'b1;
         run_reg  <= '1;
         gap_reg  <= '1;
         fr_reg   <= '1;
         stb_reg  <= '0;
         pend_reg <= 1'b0;
      end
      else
      begin
         prev_reg <= tx_data;
         run_reg  <= (tx_data != prev_reg) ? 17'h1 : run_reg + {16'h0, ~&run_reg};
         gap_reg  <= rise_w ? 17'h1 : gap_reg + {16'h0, ~&gap_reg};
         fr_reg   <= start_w ? 17'h1 : fr_reg + {16'h0, ~&fr_reg};
         stb_reg  <= strobe ? stb_reg + {8'h0, ~&stb_reg} : 9'h0;
         pend_reg <= rise_w ? 1'b1 : (start_w ? 1'b0 : pend_reg);
      end
   end
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   property p_low_run;
      tx_data && !prev_reg && $past(tx_en) |->
         (run_reg % 17'(BIT_CYCLES) == 0) && (run_reg <= 17'(9 * BIT_CYCLES));
   endproperty
   a_low_run: assert property (p_low_run) else $error("low run off bit grid");
   property p_high_run;
      inner_w |-> run_reg % 17'(BIT_CYCLES) == 0;
   endproperty
   a_high_run: assert property (p_high_run) else $error("high run off bit grid");
   property p_frame_strobe;
      start_w |-> pend_reg;
   endproperty
   a_frame_strobe: assert property (p_frame_strobe) else $error("frame with no strobe");
   property p_fall_en;
      // the enable pin reaches the frame engine through its synchroniser
      !tx_data && prev_reg |-> $past(tx_en, 5);
   endproperty
   a_fall_en: assert property (p_fall_en) else $error("sent while disabled");
   property p_drop_idle;
      !tx_en [*6] |-> tx_data;
   endproperty
   a_drop_idle: assert property (p_drop_idle) else $error("line not idle");
   property p_frame_len;
      inner_w |-> fr_reg < 17'(59 * BIT_CYCLES);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame too long");
   property p_gap;
      rise_w |-> gap_reg >= 17'(FAST_PERIOD_CYC - 2);
   endproperty
   a_gap: assert property (p_gap) else $error("strobes too close");
   property p_served;
      rise_w && tx_en |-> ##[1:20] start_w;
   endproperty
   a_served: assert property (p_served) else $error("strobe not answered");
   c_frame: cover property (start_w);
   c_drop: cover property ($fell(tx_en));
   c_fail: cover property ($fell(health_ok));
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   import grr_pkg::*;
   logic        sys_clk_in;
   logic        reset_in;
   logic        sample_req;
   logic        fast_var;
   logic        gated;
   logic        en_req;
   logic        taken;
   logic [7:0]  rx_byte;
   logic        rx_valid;
   logic        host_ok;
   logic [15:0] angle;
   logic        bit_fail;
   logic        busy;
   logic        hit;
   logic [31:0] seed;
   logic [7:0]  rxq[$];
   int          fail_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          t_last = 0;
   grr_if link_if ();
   grr_host #(.POWERUP_CYC(50)) u_grr_host (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .link(link_if), .sample_req_in(sample_req), .fast_variant_in(fast_var),
      .gated_mode_in(gated), .enable_req_in(en_req), .sample_taken_out(taken),
      .rx_byte_out(rx_byte), .rx_valid_out(rx_valid), .health_ok_out(host_ok));
   grr_device #(.PROC_CYC(300)) u_grr_device (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .link(link_if), .angle_in(angle), .bit_fail_in(bit_fail), .busy_out(busy));
   grr_link_props u_grr_link_props (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .strobe(link_if.strobe), .tx_en(link_if.tx_en), .tx_data(link_if.tx_data),
      .health_ok(link_if.health_ok));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_byte(input int i, input logic [15:0] a, input logic f);
      case (i)
         0: return f ? STATUS_BIT_FAIL : STATUS_NORMAL;
         1: return a[15:8];
         2: return a[7:0];
         default: return 8'h00;
      endcase
   endfunction
   initial
   begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   // received bytes collected in the background, away from the launching edge
   always @(negedge sys_clk_in)
   begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1)
         rxq.push_back(rx_byte);
   end
   task automatic do_sample();
      logic ok;
      ok = 1'b0;
      sample_req = 1'b1;
      // accept is combinational and gone after its edge, so look before it
      for (int k = 0; k < 100 && !ok; k++)
      begin
         #1;
         ok = (taken === 1'b1);
         @(negedge sys_clk_in);
      end
      t_last = cyc;
      sample_req = 1'b0;
      `CHK(ok, 1'b1) // taken
   endtask
   task automatic wait_bytes(input int n);
      for (int k = 0; k < 15000 && rxq.size() < n; k++)
         @(negedge sys_clk_in);
   endtask
   task automatic check_frame(input int n, input logic [15:0] a, input logic f);
      for (int i = 0; i < n; i++)
         `CHK(rxq[i], exp_byte(i, a, f)) // byte
   endtask
   // status byte sampled on the wire at mid-bit
   task automatic sniff_status();
      for (int k = 0; k < 50 && link_if.tx_data !== 1'b0; k++)
         @(negedge sys_clk_in);
      repeat (BIT_CYCLES / 2) @(negedge sys_clk_in);
      `CHK(link_if.tx_data, 1'b0) // start
      for (int b = 0; b < 8; b++)
      begin
         repeat (BIT_CYCLES) @(negedge sys_clk_in);
         `CHK(link_if.tx_data, STATUS_NORMAL[b]) // order
      end
      repeat (BIT_CYCLES) @(negedge sys_clk_in);
      `CHK(link_if.tx_data, 1'b1) // stop
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #(110000 * 5);
      fail_count++;
      complete_run();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      reset_in = 1'b1;
      {sample_req, gated, en_req, bit_fail, hit} = '0;
      fast_var = 1'b1;
      angle = 16'h0000;
      seed = 32'hEC06;
      repeat (3) @(negedge sys_clk_in);
      reset_in = 1'b0;
      repeat (10) @(negedge sys_clk_in);
      `CHK(host_ok, 1'b0) // masked
      `CHK(link_if.health_ok, 1'b1) // ok
      repeat (60) @(negedge sys_clk_in);
      `CHK(host_ok, 1'b1) // valid
      $display("test power_up done");
      seed = lfsr(seed);
      angle = seed[15:0];
      do_sample();
      sniff_status();
      wait_bytes(6);
      check_frame(6, angle, 1'b0); // frame
      $display("test continuous done");
      // gated: device must hold the frame until enabled, then obey the drop
      wait (cyc >= t_last + FAST_PERIOD_CYC + 100);
      @(negedge sys_clk_in);
      // this sample is taken after the fast variant's period and starts the slow variant's period
      {gated, bit_fail, fast_var} = 3'b110;
      seed = lfsr(seed);
      angle = seed[15:0];
      rxq.delete();
      repeat (3) @(negedge sys_clk_in);
      `CHK(link_if.health_ok, 1'b0) // fail
      do_sample();
      repeat (2000) @(negedge sys_clk_in);
      `CHK(busy, 1'b1) // held
      `CHK(link_if.tx_data, 1'b1) // idle
      en_req = 1'b1;
      wait_bytes(2);
      en_req = 1'b0;
      repeat (20) @(negedge sys_clk_in);
      en_req = 1'b1;
      repeat (12000) @(negedge sys_clk_in);
      `CHK(rxq.size(), 2) // rest dropped
      check_frame(2, angle, 1'b1); // status
      $display("test gated done");
      // slow variant must refuse what the fast one accepts
      wait (cyc >= t_last + FAST_PERIOD_CYC + 100);
      @(negedge sys_clk_in);
      {gated, bit_fail, fast_var, sample_req} = 4'b0001;
      seed = lfsr(seed);
      angle = seed[15:0];
      rxq.delete();
      for (int k = 0; k < 50; k++)
      begin
         #1;
         hit = hit | (taken === 1'b1);
         @(negedge sys_clk_in);
      end
      `CHK(hit, 1'b0) // refused
      // only a reset clears the long slow gap within this run
      {sample_req, reset_in} = 2'b01;
      repeat (3) @(negedge sys_clk_in);
      reset_in = 1'b0;
      fast_var = 1'b1;
      do_sample();
      wait_bytes(6);
      check_frame(6, angle, 1'b0); // next frame
      $display("test rate done");
      complete_run();
   end
endmodule
